// File: verilog/rx_recovery_pkg.sv
// Shared constants, types and register map of the receive recovery block
package rx_recovery_pkg;

    // ============================================================
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LIVE = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;

    // ============================================================
    // Field positions
    localparam int CFG_W = 3;
    localparam int CTRL_POLARITY_BIT = 0;
    localparam int CTRL_MUTE_BIT = 1;
    localparam int CTRL_LOOP_BIT = 2;

    localparam int LIVE_W = 3;
    localparam int LIVE_LOSS_BIT = 0;
    localparam int LIVE_LOCK_BIT = 1;
    localparam int LIVE_DATA_REF_BIT = 2;

    localparam int IRQ_W = 3;
    localparam int EV_LOSS_BIT = 0;
    localparam int EV_LOCK_LOST_BIT = 1;
    localparam int EV_LOCK_GAIN_BIT = 2;

    // ============================================================
    // Reset values
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;
    localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;

    // ============================================================
    // Frequency supervision and word format
    localparam int PPM_TOLERANCE = 500;
    localparam int PPM_SCALE = 1000000;
    localparam int WINDOW_REF_TICKS = 4000;
    localparam int FREQ_CNT_W = 14;
    localparam int WORD_W = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // ============================================================
    // Types
    typedef enum logic [1:0] {
        ST_REF_ACQ = 2'b00,
        ST_DATA_ACQ = 2'b01,
        ST_LOCKED = 2'b10
    } lock_state_t;

    typedef struct packed {
        logic loop_en;
        logic mute_en;
        logic polarity;
    } rx_cfg_t;

endpackage

// File: verilog/level_sync2.sv
// Two-stage level synchroniser
`timescale 1ns/10ps
module level_sync2
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Level in and out
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // level_sync2

// File: verilog/ppm_window_monitor.sv
// Recovered versus reference frequency check over a window of ref ticks
`timescale 1ns/10ps
module ppm_window_monitor
    import rx_recovery_pkg::*;
#(
    parameter int WINDOW = WINDOW_REF_TICKS
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Tick events
    input wire logic ref_tick,
    input wire logic rec_tick,
    // Verdict
    output logic window_done,
    output logic in_range
);
    localparam logic [FREQ_CNT_W-1:0] WIN_LAST = FREQ_CNT_W'(WINDOW - 1);
    localparam logic [FREQ_CNT_W:0] WIN_W = (FREQ_CNT_W + 1)'(WINDOW);
    localparam logic [FREQ_CNT_W:0] TOL =
        (FREQ_CNT_W + 1)'(WINDOW * PPM_TOLERANCE / PPM_SCALE);

    logic [FREQ_CNT_W-1:0] ref_cnt;
    logic [FREQ_CNT_W-1:0] rec_cnt;

    wire last_ref = ref_tick && (ref_cnt == WIN_LAST);
    wire rec_sat = (rec_cnt == {FREQ_CNT_W{1'b1}});
    wire [FREQ_CNT_W:0] rec_now = {1'b0, rec_cnt} +
        {{FREQ_CNT_W{1'b0}}, rec_tick};
    wire [FREQ_CNT_W:0] diff = (rec_now > WIN_W) ? rec_now - WIN_W
                                                 : WIN_W - rec_now;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ref_cnt <= '0;
            rec_cnt <= '0;
            window_done <= 1'b0;
            in_range <= 1'b0;
        end else begin
            window_done <= last_ref;
            if (last_ref) begin
                ref_cnt <= '0;
                rec_cnt <= '0;
                in_range <= (diff <= TOL);
            end else begin
                if (ref_tick) begin
                    ref_cnt <= ref_cnt + 1'b1;
                end
                // Saturate so a runaway VCO cannot wrap into range
                if (rec_tick && !rec_sat) begin
                    rec_cnt <= rec_cnt + 1'b1;
                end
            end
        end
    end
endmodule // ppm_window_monitor

// File: verilog/rx_recovery_control.sv
// Receive lock supervision, signal loss, mute, deserializer and loopback
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
module rx_recovery_control
    import rx_recovery_pkg::*;
#(
    parameter int WINDOW = WINDOW_REF_TICKS
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Configuration pins
    input wire logic control_source_select,
    input wire logic pin_polarity,
    input wire logic pin_mute_on_signal_loss,
    input wire logic pin_serial_remote_loop_en,
    input wire logic rx_output_disable,
    // Optical module and recovery front end
    input wire logic optical_signal_detect_in,
    input wire logic ref_clock_pair,
    input wire logic rec_bit_tick,
    input wire logic rx_serial_in,
    input wire logic tx_serial_from_piso,
    // Recovery status
    output logic cdr_track_data,
    output logic recovery_lock_flag,
    output logic signal_loss_out,
    // Parallel receive side
    output logic [WORD_W-1:0] rx_parallel_data,
    output logic rx_parallel_clock_out,
    // Serial transmit side
    output logic tx_serial_out,
    output logic tx_retimer_recovered_sel,
    // Interrupt
    output logic irq
);
    // ============================================================
    // Configuration source
    rx_cfg_t cfg_reg;
    rx_cfg_t pin_cfg;
    rx_cfg_t cfg;

    assign pin_cfg = '{loop_en: pin_serial_remote_loop_en,
                       mute_en: pin_mute_on_signal_loss,
                       polarity: pin_polarity};
    assign cfg = control_source_select ? cfg_reg : pin_cfg;

    // ============================================================
    // Signal loss
    logic loss_sync;
    logic loss_prev;

    // Polarity must match the module's detect level, else muting inverts
    wire loss_raw = optical_signal_detect_in ^ cfg.polarity;

    level_sync2 u_loss_sync (
        .clk(clk),
        .nrst(nrst),
        .d(loss_raw),
        .q(loss_sync)
    );

    wire mute_now = loss_sync && cfg.mute_en;

    // ============================================================
    // Reference tick and frequency supervision
    logic ref_prev;
    logic window_done;
    logic in_range;

    // Inputs are synchronous, so a plain edge detect is safe here
    wire ref_tick = ref_clock_pair && !ref_prev;

    ppm_window_monitor #(
        .WINDOW(WINDOW)
    ) u_ppm (
        .clk(clk),
        .nrst(nrst),
        .ref_tick(ref_tick),
        .rec_tick(rec_bit_tick),
        .window_done(window_done),
        .in_range(in_range)
    );

    wire good_window = window_done && in_range;
    wire bad_window = window_done && !in_range;

    // ============================================================
    // Lock state machine
    lock_state_t state;
    lock_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            ST_REF_ACQ: begin
                if (good_window && !loss_sync) begin
                    next_state = ST_DATA_ACQ;
                end
            end
            ST_DATA_ACQ: begin
                if (loss_sync || bad_window) begin
                    next_state = ST_REF_ACQ;
                end else if (good_window) begin
                    next_state = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                if (loss_sync || bad_window) begin
                    next_state = ST_REF_ACQ;
                end
            end
            default: begin
                next_state = ST_REF_ACQ;
            end
        endcase
    end

    wire next_lock = (next_state == ST_LOCKED);
    wire next_track = (next_state != ST_REF_ACQ);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_REF_ACQ;
            recovery_lock_flag <= 1'b0;
            cdr_track_data <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            state <= next_state;
            recovery_lock_flag <= next_lock;
            cdr_track_data <= next_track;
            ref_prev <= ref_clock_pair;
        end
    end

    // ============================================================
    // Bit clock and divide by four
    logic [1:0] phase;
    logic [WORD_W-2:0] shift;
    logic first_bit;

    // Outside data tracking (ST_REF_ACQ) the word clock falls back to the reference ticks
    wire bit_tick = cdr_track_data ? rec_bit_tick : ref_tick;
    wire [1:0] next_phase = bit_tick ? phase + 2'h1 : phase;
    wire word_strobe = bit_tick && (phase == PHASE_LAST);
    wire [WORD_W-1:0] word = {shift, rx_serial_in};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase <= 2'h0;
            shift <= '0;
            first_bit <= 1'b0;
            rx_parallel_clock_out <= 1'b0;
        end else begin
            phase <= next_phase;
            rx_parallel_clock_out <= ~next_phase[1];
            if (bit_tick) begin
                shift <= word[WORD_W-2:0];
            end
            if (bit_tick && (phase == 2'h0)) begin
                first_bit <= rx_serial_in;
            end
        end
    end

    // ============================================================
    // Parallel data output
    // Disable acts at the next edge: outputs must stay registered
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_parallel_data <= '0;
        end else if (rx_output_disable || mute_now) begin
            rx_parallel_data <= '0;
        end else if (word_strobe) begin
            rx_parallel_data <= word;
        end
    end

    // ============================================================
    // Serial remote loopback and status pin
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_serial_out <= 1'b0;
            tx_retimer_recovered_sel <= 1'b0;
            signal_loss_out <= 1'b0;
            loss_prev <= 1'b0;
        end else begin
            tx_serial_out <= cfg.loop_en ? rx_serial_in
                                         : tx_serial_from_piso;
            tx_retimer_recovered_sel <= cfg.loop_en;
            signal_loss_out <= loss_sync;
            loss_prev <= loss_sync;
        end
    end

    // ============================================================
    // Register port
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] events;

    wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    wire wr_clear = reg_wr && (reg_addr == OFS_IRQ_CLEAR);
    wire wr_enable = reg_wr && (reg_addr == OFS_IRQ_ENABLE);
    wire [IRQ_W-1:0] clear_mask = wr_clear ? reg_wdata[IRQ_W-1:0] : '0;

    assign events[EV_LOSS_BIT] = loss_sync && !loss_prev;
    assign events[EV_LOCK_LOST_BIT] = recovery_lock_flag && !next_lock;
    assign events[EV_LOCK_GAIN_BIT] = !recovery_lock_flag && next_lock;

    // Set beats clear so an event in the clearing cycle survives
    wire [IRQ_W-1:0] next_irq_status = (irq_status & ~clear_mask) | events;

    wire [LIVE_W-1:0] live;
    assign live[LIVE_LOSS_BIT] = signal_loss_out;
    assign live[LIVE_LOCK_BIT] = recovery_lock_flag;
    assign live[LIVE_DATA_REF_BIT] = cdr_track_data;

    wire [DATA_W-1:0] rd_value =
        (reg_addr == OFS_CTRL) ? {{(DATA_W-CFG_W){1'b0}}, cfg_reg} :
        (reg_addr == OFS_LIVE) ? {{(DATA_W-LIVE_W){1'b0}}, live} :
        (reg_addr == OFS_IRQ_STATUS) ?
            {{(DATA_W-IRQ_W){1'b0}}, irq_status} :
        (reg_addr == OFS_IRQ_ENABLE) ?
            {{(DATA_W-IRQ_W){1'b0}}, irq_enable} :
        '0;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_reg <= CTRL_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
            irq_status <= IRQ_STATUS_RESET;
            irq <= 1'b0;
            reg_rdata <= '0;
        end else begin
            if (wr_ctrl) begin
                cfg_reg <= reg_wdata[CFG_W-1:0];
            end
            if (wr_enable) begin
                irq_enable <= reg_wdata[IRQ_W-1:0];
            end
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & (wr_enable ? reg_wdata[IRQ_W-1:0]
                                                  : irq_enable));
            reg_rdata <= reg_rd ? rd_value : '0;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_loss_pin_follow: assert property (
        (loss_raw == 1'b1) [*4] |-> signal_loss_out)
        else $error("signal loss output not high after steady loss");

    a_mute_on_loss: assert property (
        mute_now |=> (rx_parallel_data == 4'h0))
        else $error("data not muted during signal loss");

    a_disable_zero: assert property (
        rx_output_disable |=> (rx_parallel_data == 4'h0))
        else $error("data not zero while output disabled");

    a_lock_on_loss: assert property (
        loss_sync |=> (!recovery_lock_flag && !cdr_track_data))
        else $error("lock kept during signal loss");

    a_ppm_fallback: assert property (
        (bad_window && (state != ST_REF_ACQ))
        |=> (!recovery_lock_flag && (state == ST_REF_ACQ)))
        else $error("no fallback after out of range window");

    a_relock_data: assert property (
        ((state == ST_DATA_ACQ) && good_window && !loss_sync)
        |=> recovery_lock_flag)
        else $error("no lock after good window");

    a_startup_ref: assert property (
        ((state == ST_REF_ACQ) && !(good_window && !loss_sync))
        |=> !cdr_track_data)
        else $error("left reference without a good window");

    a_first_bit_msb: assert property (
        (word_strobe && !mute_now && !rx_output_disable)
        |=> (rx_parallel_data[3] == $past(first_bit)))
        else $error("earliest bit not on top output bit");

    a_loop_route: assert property (
        cfg.loop_en |=> ((tx_serial_out == $past(rx_serial_in))
                         && tx_retimer_recovered_sel))
        else $error("loopback path not selected");

    a_ref_clock_run: assert property (
        (!cdr_track_data && ref_tick && (phase == PHASE_LAST))
        |=> (rx_parallel_clock_out && (phase == 2'h0)))
        else $error("word clock stopped while on reference");

    a_word_clock_rise: assert property (
        word_strobe |=> $rose(rx_parallel_clock_out))
        else $error("word clock not rising with the word");

    a_loss_two_stage: assert property (
        loss_sync |-> $past(loss_raw, 2))
        else $error("signal loss skipped a synchroniser stage");

    a_loss_event_set: assert property (
        (loss_sync && !loss_prev) |=> irq_status[EV_LOSS_BIT])
        else $error("signal loss not recorded in status");

    a_host_loop_off: assert property (
        (control_source_select && !cfg_reg.loop_en)
        |=> !tx_retimer_recovered_sel)
        else $error("host loop setting not applied");

    a_pin_loop_on: assert property (
        (!control_source_select && pin_serial_remote_loop_en)
        |=> tx_retimer_recovered_sel)
        else $error("pin loop setting not applied");

    a_loop_deser: assert property (
        (cfg.loop_en && word_strobe && !mute_now && !rx_output_disable)
        |=> (rx_parallel_data == $past(word)))
        else $error("parallel data stopped during remote loop");
endmodule // rx_recovery_control

// File: verif/rx_far_side_model.sv
// Optical module and reference source model for the receive block
`timescale 1ns/10ps
module rx_far_side_model
(
    // Clock
    input wire logic clk,
    // Stimulus controls
    input wire logic [31:0] pattern,
    input wire logic fast,
    input wire logic light,
    input wire logic module_hi,
    // Receive side pins
    output logic ref_clock_pair,
    output logic rec_bit_tick,
    output logic rx_serial_in,
    output logic optical_signal_detect_in
);
    // ====================
    // Line model
    logic [4:0] idx = 5'h00;

    initial begin
        ref_clock_pair = 1'h0;
        rec_bit_tick = 1'h0;
        rx_serial_in = 1'h0;
    end

    // Detect pin follows the module's own active level
    assign optical_signal_detect_in = module_hi ? light : !light;

    // Bits hold two cycles so both tick sources sample the same bit
    always @(posedge clk) begin
        ref_clock_pair <= !ref_clock_pair;
        rec_bit_tick <= fast | !ref_clock_pair;
        if (!light)
            rx_serial_in <= !rx_serial_in;
        else if (!ref_clock_pair) begin
            rx_serial_in <= pattern[idx];
            idx <= idx + 5'h01;
        end
    end
endmodule // rx_far_side_model

// File: verif/rx_recovery_control_tb.sv
// Self-checking bench for the receive recovery control block
`timescale 1ns/10ps
module rx_recovery_control_tb
    import rx_recovery_pkg::*;
;
    // ====================
    // Signals and bench model state
    localparam int WIN = 2000;
    localparam int WC = 2 * WIN;
    logic clk = 1'h0, nrst = 1'h0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic reg_wr = 1'h0, reg_rd = 1'h0;
    logic control_source_select = 1'h0, pin_polarity = 1'h0;
    logic pin_mute_on_signal_loss = 1'h1, pin_serial_remote_loop_en = 1'h0;
    logic rx_output_disable = 1'h0, tx_serial_from_piso = 1'h0;
    logic optical_signal_detect_in, ref_clock_pair, rec_bit_tick;
    logic rx_serial_in, cdr_track_data, recovery_lock_flag;
    logic signal_loss_out, irq, rx_parallel_clock_out;
    logic tx_serial_out, tx_retimer_recovered_sel;
    logic [WORD_W-1:0] rx_parallel_data, exp_w;
    logic [31:0] pattern = 32'h0;
    logic fast = 1'h0, light = 1'h1, module_hi = 1'h0;
    logic bits[$];
    logic [2:0] ctrl_m = 3'h0;
    logic [4:0] pcnt = 5'h00;
    logic exp_loop = 1'h0, exp_tx = 1'h0, tx_ok = 1'h0, pclk_prev = 1'h0;
    bit chk_words = 1'b0;
    int rises = 0, gap = 0, failures = 0, comparisons = 0;

    // ====================
    // Instances and clock
    rx_recovery_control #(.WINDOW(WIN)) u_rx_recovery_control (
        .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .control_source_select, .pin_polarity, .pin_mute_on_signal_loss,
        .pin_serial_remote_loop_en, .rx_output_disable,
        .optical_signal_detect_in, .ref_clock_pair, .rec_bit_tick,
        .rx_serial_in, .tx_serial_from_piso, .cdr_track_data,
        .recovery_lock_flag, .signal_loss_out, .rx_parallel_data,
        .rx_parallel_clock_out, .tx_serial_out, .tx_retimer_recovered_sel,
        .irq
    );
    rx_far_side_model u_rx_far_side_model (
        .clk, .pattern, .fast, .light, .module_hi, .ref_clock_pair,
        .rec_bit_tick, .rx_serial_in, .optical_signal_detect_in
    );
    always #4 clk = !clk;

    // ====================
    // Compare and bus tasks
    task automatic test_done();
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, exp);
        chk_val({31'h0, got}, {31'h0, exp}, "pin");
    endtask
    task automatic chk_word(input logic [3:0] got, exp);
        chk_val({28'h0, got}, {28'h0, exp}, "word");
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [2:0] d);
        reg_addr <= a;
        reg_wdata <= {29'h0, d};
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk_val(reg_rdata, e, "register");
        @(posedge clk);
    endtask
    function automatic logic flag(input int sel);
        case (sel)
            0: return irq;
            1: return recovery_lock_flag;
            2: return cdr_track_data;
            default: return signal_loss_out;
        endcase
    endfunction
    // Bounded wait: a limit that runs out shows up as a mismatch
    task automatic wait_flag(input int sel, input logic want, input int max);
        int n;
        n = 0;
        @(negedge clk);
        while (n < max && flag(sel) !== want) begin
            @(negedge clk);
            n++;
        end
        chk_pin(flag(sel), want);
        @(posedge clk);
    endtask
    task automatic loss_delay(input logic want, input int exp_n);
        int n;
        n = 0;
        @(negedge clk);
        while (n < 8 && signal_loss_out !== want) begin
            @(posedge clk);
            n++;
            @(negedge clk);
        end
        chk_val(n, exp_n, "loss delay");
        chk_pin(signal_loss_out, want);
        @(posedge clk);
    endtask

    // ====================
    // Reference model of bit history and transmit path
    always @(posedge clk) begin
        if (rec_bit_tick)
            bits.push_back(rx_serial_in);
        if (bits.size() > 4)
            void'(bits.pop_front());
        exp_loop = pin_serial_remote_loop_en;
        if (control_source_select)
            exp_loop = ctrl_m[2];
        exp_tx = exp_loop ? rx_serial_in : tx_serial_from_piso;
        tx_ok = nrst;
        if (!nrst)
            ctrl_m <= 3'h0;
        else if (reg_wr && reg_addr == OFS_CTRL)
            ctrl_m <= reg_wdata[2:0];
        tx_serial_from_piso <= pattern[pcnt];
        pcnt <= pcnt + 5'h03;
    end
    always @(negedge clk) begin
        if (tx_ok) begin
            chk_pin(tx_serial_out, exp_tx);
            chk_pin(tx_retimer_recovered_sel, exp_loop);
        end
        gap++;
        if (rx_parallel_clock_out && !pclk_prev) begin
            if (chk_words) begin
                exp_w = {bits[0], bits[1], bits[2], bits[3]};
                chk_word(rx_parallel_data, exp_w);
                chk_val(gap, 8, "word period");
            end
            rises++;
            gap = 0;
        end
        pclk_prev = rx_parallel_clock_out;
    end

    // ====================
    // Scenarios
    initial begin
        int r0;
        void'($urandom(32'hA25C652E));
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        pattern <= $urandom();
        @(posedge clk);
        chk_reg(OFS_CTRL, 32'h0);
        chk_reg(OFS_IRQ_ENABLE, 32'h0);
        chk_reg(OFS_IRQ_STATUS, 32'h0);
        chk_reg(8'h14, 32'h0);
        wr(OFS_IRQ_ENABLE, 3'h7);
        chk_reg(OFS_IRQ_ENABLE, 32'h7);
        wait_flag(2, 1'h1, 3 * WC);
        wait_flag(1, 1'h0, 0);
        wait_flag(1, 1'h1, 2 * WC);
        wait_flag(0, 1'h1, 0);
        chk_reg(OFS_IRQ_STATUS, 32'h4);
        wr(OFS_IRQ_ENABLE, 3'h3);
        wait_flag(0, 1'h0, 0);
        wr(OFS_IRQ_ENABLE, 3'h7);
        wait_flag(0, 1'h1, 0);
        wr(OFS_IRQ_CLEAR, 3'h4);
        wait_flag(0, 1'h0, 0);
        chk_reg(OFS_IRQ_STATUS, 32'h0);
        chk_words = 1'b1;
        pin_serial_remote_loop_en <= 1'h1;
        repeat (100) @(posedge clk);
        chk_words = 1'b0;
        // Recovered clock at twice the reference rate
        fast <= 1'h1;
        wait_flag(1, 1'h0, 3 * WC);
        wait_flag(2, 1'h0, 0);
        chk_reg(OFS_IRQ_STATUS, 32'h2);
        fast <= 1'h0;
        wr(OFS_IRQ_CLEAR, 3'h7);
        wait_flag(1, 1'h1, 4 * WC);
        // Every detect and polarity pairing; the last one matches
        module_hi <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            light <= i[1];
            pin_polarity <= i[0];
            loss_delay(i[1] ^ i[0], i[0] ? 3 : 0);
            if (i[1] ^ i[0]) begin
                wait_flag(1, 1'h0, 0);
                wait_flag(2, 1'h0, 0);
                r0 = rises;
                repeat (64) begin
                    @(negedge clk);
                    chk_word(rx_parallel_data, 4'h0);
                end
                @(posedge clk);
                chk_val(rises - r0, 8, "clock in loss");
            end
        end
        wait_flag(1, 1'h1, 4 * WC);
        chk_reg(OFS_IRQ_STATUS, 32'h7);
        wr(OFS_IRQ_CLEAR, 3'h7);
        rx_output_disable <= 1'h1;
        @(posedge clk);
        repeat (16) begin
            @(negedge clk);
            chk_word(rx_parallel_data, 4'h0);
        end
        @(posedge clk);
        rx_output_disable <= 1'h0;
        repeat (12) @(posedge clk);
        chk_words = 1'b1;
        repeat (40) @(posedge clk);
        // Pins now match the host copy of the settings
        pin_mute_on_signal_loss <= 1'h0;
        wr(OFS_CTRL, 3'h5);
        chk_reg(OFS_CTRL, 32'h5);
        wr(OFS_LIVE, 3'h0);
        chk_reg(OFS_LIVE, 32'h6);
        control_source_select <= 1'h1;
        repeat (100) @(posedge clk);
        chk_words = 1'b0;
        wr(OFS_CTRL, 3'h2);
        repeat (3) @(posedge clk);
        wait_flag(3, 1'h1, 0);
        chk_reg(OFS_LIVE, 32'h1);
        repeat (16) begin
            @(negedge clk);
            chk_word(rx_parallel_data, 4'h0);
        end
        test_done();
    end

    // Longest legal run is about sixteen windows
    initial begin
        #(24 * WC * 8);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end
endmodule // rx_recovery_control_tb
